// >>> rtl/clk_ctl.sv
// Clock source selection, tunable oscillator control and modulator
//
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
`include "clk_ctl_defs.svh"

module clk_ctl (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register port
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // Oscillator pins
  input wire logic crystal1_clock,
  input wire logic crystal2_clock,
  input wire logic tunable_osc_clock,
  input wire logic osc_fault_a,
  input wire logic osc_fault_b,
  // Oscillator controls
  output logic tune_osc_en,
  output logic dc_gen_en,
  output logic ext_resistor,
  output logic [2:0] range_sel,
  output logic [2:0] osc_step,
  output logic crystal1_en,
  output logic crystal1_hf_sel,
  output logic crystal2_en,
  // Generated clocks and fault request
  output logic aux_clock,
  output logic main_clock,
  output logic sub_main_clock,
  output logic fault_nmi
);
  logic [2:0] step_sel;
  logic [4:0] mod_count;
  logic [1:0] aux_div;
  logic [1:0] main_src_sel;
  logic [1:0] main_div;
  logic sub_src_sel;
  logic [1:0] sub_div;
  logic dc_gen_off;
  logic sub_clock_off;
  logic crystal1_off;
  logic core_clock_halt;
  logic crystal2_off;
  logic osc_fault_flag;
  logic fault_ie;
  logic forced_tune;
  logic x1_lvl;
  logic x2_lvl;
  logic tune_lvl;
  logic fa_lvl;
  logic fb_lvl;
  logic tune_prev;
  logic x1_prev;
  logic tune_rise;
  logic x1_rise;
  logic [4:0] frame_pos;
  logic [2:0] aux_cnt;
  logic [1:0] aux_cur_div;
  logic main_needs_tune;
  logic sub_needs_tune;
  logic main_fault;
  logic x1_fault;
  logic fault_any;
  logic use_next;
  clk_ctl_pkg::clk_src_t main_sel;
  clk_ctl_pkg::clk_src_t sub_sel;
  clk_ctl_pkg::clk_src_t main_cur;
  clk_ctl_pkg::clk_src_t sub_cur;
  logic main_raw;
  logic sub_raw;

  pin_sync u_x1 (.clk(clk), .reset(reset), .pin(crystal1_clock), .level(x1_lvl));
  pin_sync u_x2 (.clk(clk), .reset(reset), .pin(crystal2_clock), .level(x2_lvl));
  pin_sync u_tune (.clk(clk), .reset(reset), .pin(tunable_osc_clock), .level(tune_lvl));
  pin_sync u_fa (.clk(clk), .reset(reset), .pin(osc_fault_a), .level(fa_lvl));
  pin_sync u_fb (.clk(clk), .reset(reset), .pin(osc_fault_b), .level(fb_lvl));

  // Source decode
  function automatic clk_ctl_pkg::clk_src_t main_decode(input logic [1:0] s);
    if (!s[1]) begin
      main_decode = clk_ctl_pkg::SRC_TUNE;
    end else if (s[0] || !`HAS_XTAL2) begin
      main_decode = clk_ctl_pkg::SRC_XTAL1;
    end else begin
      main_decode = clk_ctl_pkg::SRC_XTAL2;
    end
  endfunction

  // Crystal1 fault only detected in high-frequency mode
  assign x1_fault = fa_lvl && crystal1_hf_sel;
  assign fault_any = x1_fault || fb_lvl;
  assign main_fault = (main_decode(main_src_sel) == clk_ctl_pkg::SRC_XTAL1) ? x1_fault :
                      (main_decode(main_src_sel) == clk_ctl_pkg::SRC_XTAL2) ? fb_lvl : 1'h0;
  assign main_sel = forced_tune ? clk_ctl_pkg::SRC_TUNE : main_decode(main_src_sel);
  assign sub_sel = sub_src_sel ? (`HAS_XTAL2 ? clk_ctl_pkg::SRC_XTAL2 : clk_ctl_pkg::SRC_XTAL1)
                               : clk_ctl_pkg::SRC_TUNE;
  assign main_needs_tune = !core_clock_halt && main_sel == clk_ctl_pkg::SRC_TUNE;
  assign sub_needs_tune = !sub_clock_off && sub_sel == clk_ctl_pkg::SRC_TUNE;
  assign tune_rise = tune_lvl && !tune_prev;
  assign x1_rise = x1_lvl && !x1_prev;
  assign use_next = frame_pos < mod_count && step_sel != 3'h7;

  clk_switch_div u_main (.clk(clk), .reset(reset), .tune_lvl(tune_lvl), .xtal1_lvl(x1_lvl),
    .xtal2_lvl(x2_lvl), .sel(main_sel), .div(main_div), .gate_off(core_clock_halt),
    .src_dead(forced_tune), .clk_out(main_raw), .cur_src(main_cur));
  clk_switch_div u_sub (.clk(clk), .reset(reset), .tune_lvl(tune_lvl), .xtal1_lvl(x1_lvl),
    .xtal2_lvl(x2_lvl), .sel(sub_sel), .div(sub_div), .gate_off(sub_clock_off),
    .src_dead(1'h0), .clk_out(sub_raw), .cur_src(sub_cur));

  // Register writes; any field may change at any time
  always_ff @(posedge clk) begin
    if (reset) begin
      step_sel <= 3'(`TUNE_RESET >> `STEP_LSB);
      mod_count <= 5'h00;
      range_sel <= 3'(`CTL1_RESET >> `RANGE_LSB);
      aux_div <= 2'h0;
      crystal1_hf_sel <= 1'h0;
      crystal2_off <= 1'h1;
      main_src_sel <= 2'h0;
      main_div <= 2'h0;
      sub_src_sel <= 1'h0;
      sub_div <= 2'h0;
      ext_resistor <= 1'h0;
      dc_gen_off <= 1'h0;
      sub_clock_off <= 1'h0;
      crystal1_off <= 1'h0;
      core_clock_halt <= 1'h0;
      fault_ie <= 1'h0;
    end else if (wr) begin
      case (addr)
        `ADDR_TUNE: begin
          step_sel <= wdata[`STEP_LSB+2:`STEP_LSB];
          mod_count <= wdata[4:0];
        end
        `ADDR_CTL1: begin
          range_sel <= wdata[`RANGE_LSB+2:`RANGE_LSB];
          aux_div <= wdata[`AUX_DIV_LSB+1:`AUX_DIV_LSB];
          crystal1_hf_sel <= wdata[`XTAL1_HF_BIT];
          crystal2_off <= wdata[`XTAL2_OFF_BIT];
        end
        `ADDR_CTL2: begin
          main_src_sel <= wdata[`MAIN_SEL_LSB+1:`MAIN_SEL_LSB];
          main_div <= wdata[`MAIN_DIV_LSB+1:`MAIN_DIV_LSB];
          sub_src_sel <= wdata[`SUB_SEL_BIT];
          sub_div <= wdata[`SUB_DIV_LSB+1:`SUB_DIV_LSB];
          ext_resistor <= wdata[`EXT_RES_BIT];
        end
        `ADDR_MODE: begin
          dc_gen_off <= wdata[`DC_GEN_OFF_BIT];
          sub_clock_off <= wdata[`SUB_OFF_BIT];
          crystal1_off <= wdata[`XTAL1_OFF_BIT];
          core_clock_halt <= wdata[`CORE_HALT_BIT];
        end
        `ADDR_FAULT: begin
          fault_ie <= wdata[`FAULT_IE_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  // Fault flag: a live fault sets it and wins over a software clear
  always_ff @(posedge clk) begin
    if (reset) begin
      osc_fault_flag <= 1'h1;
    end else if (fault_any) begin
      osc_fault_flag <= 1'h1;
    end else if (wr && addr == `ADDR_FAULT && !wdata[`FAULT_FLAG_BIT]) begin
      osc_fault_flag <= 1'h0;
    end
  end

  // Forced fallback holds until software selects the tunable oscillator itself
  always_ff @(posedge clk) begin
    if (reset) begin
      forced_tune <= 1'h0;
    end else if (main_fault) begin
      forced_tune <= 1'h1;
    end else if (main_decode(main_src_sel) == clk_ctl_pkg::SRC_TUNE) begin
      forced_tune <= 1'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      fault_nmi <= 1'h0;
    end else begin
      fault_nmi <= osc_fault_flag && fault_ie;
    end
  end

  // Oscillator enables
  always_ff @(posedge clk) begin
    if (reset) begin
      tune_osc_en <= 1'h1;
      dc_gen_en <= 1'h1;
      crystal1_en <= 1'h1;
      crystal2_en <= 1'h0;
    end else begin
      tune_osc_en <= main_needs_tune || sub_needs_tune || main_cur == clk_ctl_pkg::SRC_TUNE
                     && !core_clock_halt || sub_cur == clk_ctl_pkg::SRC_TUNE && !sub_clock_off;
      dc_gen_en <= !dc_gen_off || main_needs_tune || sub_needs_tune;
      crystal1_en <= !crystal1_off || main_sel == clk_ctl_pkg::SRC_XTAL1 && !core_clock_halt
                     || sub_sel == clk_ctl_pkg::SRC_XTAL1 && !sub_clock_off;
      crystal2_en <= !crystal2_off || main_sel == clk_ctl_pkg::SRC_XTAL2 && !core_clock_halt
                     || sub_sel == clk_ctl_pkg::SRC_XTAL2 && !sub_clock_off;
    end
  end

  // Modulator: one decision per oscillator cycle across a 32-cycle frame
  always_ff @(posedge clk) begin
    if (reset) begin
      tune_prev <= 1'h0;
      frame_pos <= 5'h00;
      osc_step <= 3'(`TUNE_RESET >> `STEP_LSB);
    end else begin
      tune_prev <= tune_lvl;
      if (tune_rise) begin
        frame_pos <= 5'(frame_pos + 5'h01);
        osc_step <= use_next ? 3'(step_sel + 3'h1) : step_sel;
      end
    end
  end

  // Aux divider counts crystal1 rising edges
  always_ff @(posedge clk) begin
    if (reset) begin
      x1_prev <= 1'h0;
      aux_cnt <= 3'h0;
      aux_cur_div <= 2'h0;
      aux_clock <= 1'h0;
    end else begin
      x1_prev <= x1_lvl;
      if (x1_rise) begin
        if (aux_cnt == 3'h0 || aux_cur_div == 2'h0) begin
          aux_cur_div <= aux_div;
        end
        aux_cnt <= (aux_cur_div == 2'h0) ? 3'h0 :
                   3'(aux_cnt + 3'h1) & 3'((4'h1 << aux_cur_div) - 4'h1);
      end
      aux_clock <= (aux_cur_div == 2'h0) ? x1_lvl : !aux_cnt[aux_cur_div - 2'h1];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      main_clock <= 1'h0;
      sub_main_clock <= 1'h0;
    end else begin
      main_clock <= main_raw;
      sub_main_clock <= sub_raw;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rdata <= 8'h00;
    end else if (rd) begin
      case (addr)
        `ADDR_TUNE: rdata <= {step_sel, mod_count};
        `ADDR_CTL1: rdata <= {crystal2_off, crystal1_hf_sel, aux_div, 1'h0, range_sel};
        `ADDR_CTL2: rdata <= {main_src_sel, main_div, sub_src_sel, sub_div, ext_resistor};
        `ADDR_MODE: rdata <= {4'h0, core_clock_halt, crystal1_off, sub_clock_off, dc_gen_off};
        `ADDR_FAULT: rdata <= {6'h00, fault_ie, osc_fault_flag};
        `ADDR_STATUS: rdata <= {1'h0, forced_tune, 2'(sub_cur), 2'(main_cur), dc_gen_en,
                                tune_osc_en};
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end
endmodule

// >>> rtl/clk_ctl_defs.svh
// Offsets, field positions, reset values and timing counts of the clock controller
`ifndef CLK_CTL_DEFS_SVH
`define CLK_CTL_DEFS_SVH
`define ADDR_TUNE 4'h0
`define ADDR_CTL1 4'h1
`define ADDR_CTL2 4'h2
`define ADDR_MODE 4'h3
`define ADDR_FAULT 4'h4
`define ADDR_STATUS 4'h5
`define TUNE_RESET 8'h60
`define CTL1_RESET 8'h84
`define CTL2_RESET 8'h00
`define MODE_RESET 8'h00
`define MOD_FRAME 6'h20
`define STEP_LSB 5
`define RANGE_LSB 0
`define AUX_DIV_LSB 4
`define XTAL1_HF_BIT 6
`define XTAL2_OFF_BIT 7
`define MAIN_SEL_LSB 6
`define MAIN_DIV_LSB 4
`define SUB_SEL_BIT 3
`define SUB_DIV_LSB 1
`define EXT_RES_BIT 0
`define DC_GEN_OFF_BIT 0
`define SUB_OFF_BIT 1
`define XTAL1_OFF_BIT 2
`define CORE_HALT_BIT 3
`define FAULT_FLAG_BIT 0
`define FAULT_IE_BIT 1
`define HAS_XTAL2 1'h1
`endif

// >>> rtl/clk_ctl_pkg.sv
// Types shared by the clock controller files
package clk_ctl_pkg;
  typedef enum logic [1:0] {SRC_TUNE, SRC_XTAL1, SRC_XTAL2} clk_src_t;
  typedef enum {SW_RUN, SW_FINISH, SW_WAIT_NEW} switch_state_t;
endpackage

// >>> rtl/clk_switch_div.sv
// Glitch-free source switch with a power-of-two divider and a gate
`timescale 1ns/100ps
module clk_switch_div (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Synchronised source levels
  input wire logic tune_lvl,
  input wire logic xtal1_lvl,
  input wire logic xtal2_lvl,
  // Control
  input wire clk_ctl_pkg::clk_src_t sel,
  input wire logic [1:0] div,
  input wire logic gate_off,
  input wire logic src_dead,
  // Output clock
  output logic clk_out,
  output clk_ctl_pkg::clk_src_t cur_src
);
  clk_ctl_pkg::switch_state_t state;
  logic [1:0] cur_div;
  logic [2:0] cnt;
  logic src_lvl;
  logic src_prev;
  logic new_lvl;
  logic new_prev;
  logic src_rise;
  logic new_rise;
  logic div_hi;
  logic div_wrap;
  logic leave_old;

  function automatic logic pick(input clk_ctl_pkg::clk_src_t s, input logic a,
                                input logic b, input logic c);
    case (s)
      clk_ctl_pkg::SRC_XTAL1: pick = b;
      clk_ctl_pkg::SRC_XTAL2: pick = c;
      default: pick = a;
    endcase
  endfunction

  // Divided period ends on the source rise that wraps the count back to zero
  function automatic logic [2:0] wrap_mask(input logic [1:0] d);
    wrap_mask = 3'((4'h1 << d) - 4'h1);
  endfunction

  assign src_lvl = pick(cur_src, tune_lvl, xtal1_lvl, xtal2_lvl);
  assign new_lvl = pick(sel, tune_lvl, xtal1_lvl, xtal2_lvl);
  assign src_rise = src_lvl && !src_prev;
  assign new_rise = new_lvl && !new_prev;
  assign div_hi = (cur_div == 2'h0) ? src_lvl : !cnt[cur_div - 2'h1];
  assign div_wrap = src_rise && cnt == wrap_mask(cur_div);
  // A dead old source never rises, so the finish step is skipped
  assign leave_old = div_wrap || src_dead;

  always_ff @(posedge clk) begin
    if (reset) begin
      src_prev <= 1'h0;
      new_prev <= 1'h0;
    end else begin
      // Track the incoming source while waiting so the handover sees no false rise
      src_prev <= (state == clk_ctl_pkg::SW_WAIT_NEW) ? new_lvl : src_lvl;
      new_prev <= new_lvl;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= clk_ctl_pkg::SW_RUN;
      cur_src <= clk_ctl_pkg::SRC_TUNE;
    end else begin
      case (state)
        clk_ctl_pkg::SW_RUN: begin
          if (sel != cur_src) begin
            state <= clk_ctl_pkg::SW_FINISH;
          end
        end
        clk_ctl_pkg::SW_FINISH: begin
          if (leave_old) begin
            state <= clk_ctl_pkg::SW_WAIT_NEW;
          end
        end
        clk_ctl_pkg::SW_WAIT_NEW: begin
          if (new_rise) begin
            cur_src <= sel;
            state <= clk_ctl_pkg::SW_RUN;
          end
        end
        default: state <= clk_ctl_pkg::SW_RUN;
      endcase
    end
  end

  // Divider counts source rising edges; ratio loads only at a period boundary
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt <= 3'h0;
      cur_div <= 2'h0;
    end else if (state == clk_ctl_pkg::SW_WAIT_NEW) begin
      cnt <= 3'h0;
    end else if (src_rise) begin
      if (cnt == 3'h0 || cur_div == 2'h0) begin
        cur_div <= div;
      end
      cnt <= (cur_div == 2'h0) ? 3'h0 : 3'(cnt + 3'h1) & wrap_mask(cur_div);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      clk_out <= 1'h0;
    end else if (gate_off) begin
      clk_out <= 1'h0;
    end else if (state == clk_ctl_pkg::SW_WAIT_NEW
                 || (state == clk_ctl_pkg::SW_FINISH && leave_old)) begin
      clk_out <= 1'h1;
    end else begin
      clk_out <= div_hi;
    end
  end
endmodule

// >>> rtl/pin_sync.sv
// Three-stage synchroniser; output changes once stages two and three agree
`timescale 1ns/100ps
module pin_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Pin in, clean level out
  input wire logic pin,
  output logic level
);
  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge clk) begin
    if (reset) begin
      s1 <= 1'h0;
      s2 <= 1'h0;
      s3 <= 1'h0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      level <= 1'h0;
    end else if (s2 == s3) begin
      level <= s3;
    end
  end
endmodule

// >>> testbench/clk_ctl_assertions.sv
// Port-level checks of the clock controller
`timescale 1ns/100ps
`include "clk_ctl_defs.svh"
module clk_ctl_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register port
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  // Oscillator pins
  input wire logic crystal1_clock,
  input wire logic crystal2_clock,
  input wire logic tunable_osc_clock,
  input wire logic osc_fault_a,
  input wire logic osc_fault_b,
  // Oscillator controls
  input wire logic tune_osc_en,
  input wire logic dc_gen_en,
  input wire logic ext_resistor,
  input wire logic [2:0] range_sel,
  input wire logic [2:0] osc_step,
  input wire logic crystal1_en,
  input wire logic crystal1_hf_sel,
  input wire logic crystal2_en,
  // Generated clocks and fault request
  input wire logic aux_clock,
  input wire logic main_clock,
  input wire logic sub_main_clock,
  input wire logic fault_nmi
);
  logic [7:0] tune, ctl1, ctl2, mode, age;
  logic [9:0] halt_cnt, soff_cnt;
  logic fie, main_need, sub_need;
  assign main_need = !mode[`CORE_HALT_BIT] && !ctl2[7];
  assign sub_need = !mode[`SUB_OFF_BIT] && !ctl2[`SUB_SEL_BIT];
  // Shadow copies of the written settings
  always_ff @(posedge clk) begin
    if (reset) begin
      tune <= `TUNE_RESET;
      ctl1 <= `CTL1_RESET;
      ctl2 <= `CTL2_RESET;
      mode <= `MODE_RESET;
      fie <= 1'b0;
    end else if (wr) begin
      case (addr)
        `ADDR_TUNE: tune <= wdata;
        `ADDR_CTL1: ctl1 <= wdata;
        `ADDR_CTL2: ctl2 <= wdata;
        `ADDR_MODE: mode <= wdata;
        `ADDR_FAULT: fie <= wdata[`FAULT_IE_BIT];
        default: ;
      endcase
    end
  end
  // Cycles since the last write, saturating
  always_ff @(posedge clk) begin
    if (reset || wr) age <= 8'h00;
    else if (age != 8'hFF) age <= age + 8'h01;
  end
  // Cycles spent with a clock gated off, saturating
  always_ff @(posedge clk) begin
    if (reset || !mode[`CORE_HALT_BIT]) halt_cnt <= 10'h000;
    else if (halt_cnt != 10'h3FF) halt_cnt <= halt_cnt + 10'h001;
  end
  always_ff @(posedge clk) begin
    if (reset || !mode[`SUB_OFF_BIT]) soff_cnt <= 10'h000;
    else if (soff_cnt != 10'h3FF) soff_cnt <= soff_cnt + 10'h001;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  reset_values_a: assert property ($past(reset) |-> range_sel == 3'h4 && osc_step == 3'h3
    && !ext_resistor) else $error("oscillator settings wrong after reset");
  xtal1_low_a: assert property ($past(reset) |-> !crystal1_hf_sel && crystal1_en
    && !crystal2_en) else $error("crystal settings wrong after reset");
  tune_start_a: assert property ($past(reset) |-> tune_osc_en && dc_gen_en)
    else $error("tunable oscillator not running after reset");
  tune_need_a: assert property (age > 8'h03 && (main_need || sub_need) |-> tune_osc_en)
    else $error("tunable oscillator stopped while in use");
  dcgen_on_a: assert property (age > 8'h03 && (main_need || sub_need
    || !mode[`DC_GEN_OFF_BIT]) |-> dc_gen_en) else $error("dc generator off wrongly");
  main_gate_a: assert property (halt_cnt == 10'h3FF |-> $stable(main_clock))
    else $error("main clock runs while halted");
  sub_gate_a: assert property (soff_cnt == 10'h3FF |-> $stable(sub_main_clock))
    else $error("sub-main clock runs while off");
  mod_zero_a: assert property (age > 8'h28 && tune_osc_en && tune[4:0] == 5'h00
    |-> osc_step == tune[7:5]) else $error("step mixed in with zero modulation");
  mod_range_a: assert property (age > 8'h28 && tune_osc_en |-> osc_step == tune[7:5]
    || (tune[7:5] != 3'h7 && osc_step == tune[7:5] + 3'h1)) else $error("step out of range");
  xtal2_on_a: assert property (age > 8'h03 && !ctl1[`XTAL2_OFF_BIT] |-> crystal2_en)
    else $error("second crystal disabled while enabled by setting");
  nmi_mask_a: assert property (age > 8'h03 && !fie |-> !fault_nmi)
    else $error("fault request while masked");
  cover property (!main_need && !sub_need && !tune_osc_en);
  cover property (fault_nmi);
  cover property (halt_cnt == 10'h3FF);
  cover property (soff_cnt == 10'h3FF);
endmodule

// >>> testbench/clock_source_select_and_modulator_tb.sv
// Self-checking bench for the clock controller
`timescale 1ns/100ps
module clock_source_select_and_modulator_tb;
  logic clk, reset, wr, rd, stop1, stop2;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, v;
  logic crystal1_clock, crystal2_clock, tunable_osc_clock, osc_fault_a, osc_fault_b;
  logic tune_osc_en, dc_gen_en, ext_resistor, crystal1_en, crystal1_hf_sel, crystal2_en;
  logic [2:0] range_sel, osc_step;
  logic aux_clock, main_clock, sub_main_clock, fault_nmi;
  int fails, checks_done, n;
  clk_ctl dut (.*);
  osc_model osc (.*);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic near(input int got, input int lo, input int hi);
    checks_done++;
    if (got < lo || got > hi) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, lo);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  // Rising edges of aux (0), main (1) or sub-main (2) over a span of cycles
  task automatic edges(input int s, input int cyc, output int c);
    logic p, q;
    c = 0;
    p = 1'b1;
    repeat (cyc) begin
      @(negedge clk);
      q = (s == 0) ? aux_clock : (s == 1) ? main_clock : sub_main_clock;
      if ($isunknown(q)) c = 9999;
      if (q && !p) c++;
      p = q;
    end
  endtask
  // Shortest complete phase of the main clock; the first partial phase is ignored
  task automatic runs(input int cyc, output int m);
    logic p;
    int r;
    m = 999;
    r = -1000;
    p = main_clock;
    repeat (cyc) begin
      @(negedge clk);
      if (main_clock === p) r++;
      else begin
        if (r > 0 && r < m) m = r;
        r = 1;
        p = main_clock;
      end
    end
  endtask
  task automatic t_reset();
    logic [7:0] rv[6] = '{8'h60, 8'h84, 8'h00, 8'h00, 8'h01, 8'h03};
    for (int a = 0; a < 6; a++) begin
      rreg(4'(a));
      chk(v, rv[a]);
    end
    wreg(4'hF, 8'h55);
    rreg(4'hF);
    chk(v, 8'h00);
    chk({ext_resistor, crystal1_hf_sel, crystal2_en, crystal1_en, 1'b0, range_sel}, 8'h14);
    chk({5'h00, osc_step}, 8'h03);
    edges(0, 400, n);
    near(n, 19, 21);
  endtask
  task automatic t_aux();
    for (int d = 0; d < 4; d++) begin
      wreg(4'h1, {2'b10, 2'(d), 4'h4});
      repeat (200) @(posedge clk);
      edges(0, 960, n);
      near(n, (48 >> d) - 1, (48 >> d) + 1);
    end
    wreg(4'h1, 8'h84);
  endtask
  task automatic t_main();
    int ex[4] = '{91, 91, 69, 48};
    // Crystal1 in high-frequency mode before it drives main
    wreg(4'h1, 8'h44);
    repeat (4) @(posedge clk);
    chk({7'h00, crystal2_en}, 8'h01);
    for (int s = 0; s < 4; s++) begin
      wreg(4'h2, {2'(s), 6'h00});
      repeat (300) @(posedge clk);
      rreg(4'h5);
      chk({6'h00, v[3:2]}, (s < 2) ? 8'h00 : (s == 2) ? 8'h02 : 8'h01);
      edges(1, 960, n);
      near(n, ex[s] - 3, ex[s] + 3);
    end
  endtask
  task automatic t_onoff();
    logic [7:0] c2[6] = '{8'hC8, 8'hC8, 8'h08, 8'h08, 8'h00, 8'h00};
    logic [7:0] mo[6] = '{8'h00, 8'h01, 8'h01, 8'h09, 8'h0B, 8'h00};
    logic [1:0] ex[6] = '{2'b10, 2'b00, 2'b11, 2'b00, 2'b00, 2'b11};
    for (int i = 0; i < 6; i++) begin
      wreg(4'h2, c2[i]);
      wreg(4'h3, mo[i]);
      repeat (1100) @(posedge clk);
      chk({6'h00, dc_gen_en, tune_osc_en}, {6'h00, ex[i]});
      rreg(4'h5);
      chk({6'h00, v[1:0]}, {6'h00, ex[i]});
      edges(1, 200, n);
      if (mo[i][3]) near(n, 0, 0);
      edges(2, 200, n);
      if (mo[i][1]) near(n, 0, 0);
    end
  endtask
  task automatic t_mod();
    logic [7:0] tv[4] = '{8'h68, 8'h60, 8'hBF, 8'hE8};
    int ex[4] = '{80, 0, 310, 0};
    int c;
    for (int i = 0; i < 4; i++) begin
      wreg(4'h0, tv[i]);
      repeat (100) @(posedge clk);
      c = 0;
      repeat (320) begin
        @(negedge tunable_osc_clock);
        if (osc_step === tv[i][7:5] + 3'h1) c++;
      end
      near(c, ex[i] - 1, ex[i] + 1);
    end
    wreg(4'h0, 8'h60);
  endtask
  task automatic t_switch();
    logic [7:0] c2[5] = '{8'hC0, 8'hD0, 8'hE0, 8'h10, 8'h00};
    for (int i = 0; i < 5; i++) begin
      wreg(4'h2, c2[i]);
      runs(600, n);
      near(n, 4, 999);
    end
  endtask
  task automatic t_fault();
    // Enable, clear the flag and retest until it stays clear before moving main
    wreg(4'h4, 8'h02);
    for (int i = 0; i < 20; i++) begin
      repeat (50) @(posedge clk);
      rreg(4'h4);
      if (v[0] === 1'b0) break;
      wreg(4'h4, 8'h02);
    end
    chk(v, 8'h02);
    wreg(4'h2, 8'h80);
    repeat (300) @(posedge clk);
    rreg(4'h5);
    chk({6'h00, v[3:2]}, 8'h02);
    chk({7'h00, fault_nmi}, 8'h00);
    @(posedge clk) stop2 <= 1'b1;
    repeat (300) @(posedge clk);
    rreg(4'h5);
    chk({5'h00, v[6], v[3:2]}, 8'h04);
    chk({7'h00, fault_nmi}, 8'h01);
    wreg(4'h4, 8'h02);
    rreg(4'h4);
    chk(v, 8'h03);
    @(posedge clk) stop2 <= 1'b0;
    repeat (50) @(posedge clk);
    wreg(4'h4, 8'h02);
    rreg(4'h4);
    chk(v, 8'h02);
    repeat (3) @(posedge clk);
    chk({7'h00, fault_nmi}, 8'h00);
    wreg(4'h2, 8'h00);
    wreg(4'h4, 8'h00);
  endtask
  task automatic t_x1off();
    // Crystal1 unused by main and sub-main, so software turns it off
    wreg(4'h1, 8'h84);
    wreg(4'h3, 8'h04);
    repeat (20) @(posedge clk);
    chk({6'h00, crystal1_en, crystal2_en}, 8'h00);
    wreg(4'h3, 8'h00);
    repeat (20) @(posedge clk);
    chk({7'h00, crystal1_en}, 8'h01);
  endtask
  task automatic test_done();
    $display("Checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    reset = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    stop1 = 1'b0;
    stop2 = 1'b0;
    fails = 0;
    checks_done = 0;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_aux();
    t_main();
    t_onoff();
    t_mod();
    t_switch();
    t_fault();
    t_x1off();
    test_done();
  end
  initial begin
    #200000;
    fails++;
    test_done();
  end
endmodule
bind clk_ctl clk_ctl_assertions chk_i (.*);

// >>> testbench/osc_model.sv
// Behavioural oscillators feeding the clock controller
`timescale 1ns/100ps
module osc_model (
  // Enables and step from the controller
  input wire logic tune_osc_en,
  input wire logic crystal1_en,
  input wire logic crystal2_en,
  input wire logic [2:0] osc_step,
  // Crystal stop requests from the bench
  input wire logic stop1,
  input wire logic stop2,
  // Oscillator outputs
  output logic tunable_osc_clock,
  output logic crystal1_clock,
  output logic crystal2_clock,
  output logic osc_fault_a,
  output logic osc_fault_b
);
  initial begin
    tunable_osc_clock = 1'b0;
    crystal1_clock = 1'b0;
    crystal2_clock = 1'b0;
  end
  // Disabled or failed oscillators stand still low; higher step gives a shorter period
  always begin
    #(24 - int'(osc_step));
    tunable_osc_clock = (tune_osc_en === 1'b1) ? ~tunable_osc_clock : 1'b0;
  end
  always begin
    #40;
    crystal1_clock = (crystal1_en === 1'b1 && !stop1) ? ~crystal1_clock : 1'b0;
  end
  always begin
    #28;
    crystal2_clock = (crystal2_en === 1'b1 && !stop2) ? ~crystal2_clock : 1'b0;
  end
  assign osc_fault_a = stop1;
  assign osc_fault_b = stop2;
endmodule
